// *** design/lsw_pkg.sv ***
// package for the load/store and word instruction unit
// assumes a single 25 MHz core clock and a byte-wide memory port
package lsw_pkg;
	// ==========================================
	// clock and reset values
	localparam int LSW_CLK_MHZ = 25;
	localparam logic [15:0] LSW_RST_PC = 16'h0000;
	localparam logic [7:0] LSW_RST_SP = 8'hFF;
	localparam logic [7:0] LSW_RST_PSW = 8'h00;
	// ==========================================
	// status flag positions
	localparam int PSW_N = 7;
	localparam int PSW_V = 6;
	localparam int PSW_G = 5;
	localparam int PSW_H = 3;
	localparam int PSW_Z = 1;
	localparam int PSW_C = 0;
	// ==========================================
	// software register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [3:0] REG_ACC = 4'h2;
	localparam logic [3:0] REG_IDX = 4'h3;
	localparam logic [3:0] REG_IDY = 4'h4;
	localparam logic [3:0] REG_SP = 4'h5;
	localparam logic [3:0] REG_PSW = 4'h6;
	localparam logic [3:0] REG_PCL = 4'h7;
	localparam logic [3:0] REG_PCH = 4'h8;
	// ==========================================
	// opcodes watched by checks
	localparam logic [7:0] OPC_LDA_XINC = 8'hDB;
	localparam logic [7:0] OPC_STA_XINC = 8'hFB;
	localparam logic [7:0] OPC_LDM = 8'hE4;
	localparam logic [7:0] OPC_STA_DP = 8'hE5;
	localparam logic [7:0] OPC_TAX = 8'hE8;
	localparam logic [7:0] OPC_TXS = 8'h8E;
	localparam logic [7:0] OPC_XAX = 8'hEE;
	localparam logic [7:0] OPC_WCMP = 8'h5D;
	localparam logic [7:0] OPC_WADD = 8'h1D;
	localparam logic [7:0] OPC_WINC = 8'h9D;
	localparam logic [7:0] OPC_XMA_XI = 8'hBB;
	// ==========================================
	// types
	typedef enum logic [3:0] {M_IMP, M_IMM, M_DP, M_DPX, M_DPY, M_ABS, M_ABSY,
		M_IDX, M_IDY, M_XI, M_XINC, M_DPI} lsw_mode_t;
	typedef enum logic [4:0] {O_NOP, O_LDA, O_LDX, O_LDY, O_STA, O_STX, O_STY, O_STI,
		O_TAX, O_TAY, O_TSX, O_TXA, O_TXS, O_TYA, O_XAX, O_XAY, O_XYX, O_XMA,
		O_WADD, O_WSUB, O_WCMP, O_WINC, O_WDEC, O_WLD, O_WST} lsw_op_t;
	typedef enum logic [3:0] {S_FETCH, S_OPR1, S_OPR2, S_PTRLO, S_PTRHI, S_MEM,
		S_HI, S_WR1, S_WR, S_EXEC, S_PAD} lsw_state_t;
	typedef struct packed {lsw_mode_t mode; lsw_op_t op; logic [3:0] cyc; logic ill;} lsw_dec_t;
	// ==========================================
	// opcode table: mode, operation, cycle count
	function automatic lsw_dec_t lsw_decode(input logic [7:0] opc);
		lsw_dec_t d;
		d = '{M_IMP, O_NOP, 4'h2, 1'b1};
		case (opc)
			8'hC4: d = '{M_IMM, O_LDA, 4'h2, 1'b0};
			8'hC5: d = '{M_DP, O_LDA, 4'h3, 1'b0};
			8'hC6: d = '{M_DPX, O_LDA, 4'h4, 1'b0};
			8'hC7: d = '{M_ABS, O_LDA, 4'h4, 1'b0};
			8'hD5: d = '{M_ABSY, O_LDA, 4'h5, 1'b0};
			8'hD6: d = '{M_IDX, O_LDA, 4'h6, 1'b0};
			8'hD7: d = '{M_IDY, O_LDA, 4'h6, 1'b0};
			8'hD4: d = '{M_XI, O_LDA, 4'h3, 1'b0};
			OPC_LDA_XINC: d = '{M_XINC, O_LDA, 4'h4, 1'b0};
			OPC_LDM: d = '{M_DPI, O_STI, 4'h5, 1'b0};
			8'h1E: d = '{M_IMM, O_LDX, 4'h2, 1'b0};
			8'hCC: d = '{M_DP, O_LDX, 4'h3, 1'b0};
			8'hCD: d = '{M_DPY, O_LDX, 4'h4, 1'b0};
			8'hDC: d = '{M_ABS, O_LDX, 4'h4, 1'b0};
			8'h3E: d = '{M_IMM, O_LDY, 4'h2, 1'b0};
			8'hC9: d = '{M_DP, O_LDY, 4'h3, 1'b0};
			8'hD9: d = '{M_DPX, O_LDY, 4'h4, 1'b0};
			8'hD8: d = '{M_ABS, O_LDY, 4'h4, 1'b0};
			OPC_STA_DP: d = '{M_DP, O_STA, 4'h4, 1'b0};
			8'hE6: d = '{M_DPX, O_STA, 4'h5, 1'b0};
			8'hE7: d = '{M_ABS, O_STA, 4'h5, 1'b0};
			8'hF5: d = '{M_ABSY, O_STA, 4'h6, 1'b0};
			8'hF6: d = '{M_IDX, O_STA, 4'h7, 1'b0};
			8'hF7: d = '{M_IDY, O_STA, 4'h7, 1'b0};
			8'hF4: d = '{M_XI, O_STA, 4'h4, 1'b0};
			OPC_STA_XINC: d = '{M_XINC, O_STA, 4'h4, 1'b0};
			8'hEC: d = '{M_DP, O_STX, 4'h4, 1'b0};
			8'hED: d = '{M_DPY, O_STX, 4'h5, 1'b0};
			8'hFC: d = '{M_ABS, O_STX, 4'h5, 1'b0};
			8'hE9: d = '{M_DP, O_STY, 4'h4, 1'b0};
			8'hF9: d = '{M_DPX, O_STY, 4'h5, 1'b0};
			8'hF8: d = '{M_ABS, O_STY, 4'h5, 1'b0};
			OPC_TAX: d = '{M_IMP, O_TAX, 4'h2, 1'b0};
			8'h9F: d = '{M_IMP, O_TAY, 4'h2, 1'b0};
			8'hAE: d = '{M_IMP, O_TSX, 4'h2, 1'b0};
			8'hC8: d = '{M_IMP, O_TXA, 4'h2, 1'b0};
			OPC_TXS: d = '{M_IMP, O_TXS, 4'h2, 1'b0};
			8'hBF: d = '{M_IMP, O_TYA, 4'h2, 1'b0};
			OPC_XAX: d = '{M_IMP, O_XAX, 4'h4, 1'b0};
			8'hDE: d = '{M_IMP, O_XAY, 4'h4, 1'b0};
			8'hFE: d = '{M_IMP, O_XYX, 4'h4, 1'b0};
			8'hBC: d = '{M_DP, O_XMA, 4'h5, 1'b0};
			8'hAD: d = '{M_DPX, O_XMA, 4'h6, 1'b0};
			OPC_XMA_XI: d = '{M_XI, O_XMA, 4'h5, 1'b0};
			OPC_WADD: d = '{M_DP, O_WADD, 4'h5, 1'b0};
			OPC_WCMP: d = '{M_DP, O_WCMP, 4'h4, 1'b0};
			8'hBD: d = '{M_DP, O_WDEC, 4'h6, 1'b0};
			OPC_WINC: d = '{M_DP, O_WINC, 4'h6, 1'b0};
			8'h7D: d = '{M_DP, O_WLD, 4'h5, 1'b0};
			8'hDD: d = '{M_DP, O_WST, 4'h5, 1'b0};
			8'h3D: d = '{M_DP, O_WSUB, 4'h5, 1'b0};
			default: d = '{M_IMP, O_NOP, 4'h2, 1'b1};
		endcase
		return d;
	endfunction
endpackage

// *** design/lsw_exec.sv ***
// execution unit for loads, stores, transfers, swaps and word ops
// assumes a memory whose read data follow the address in the same cycle
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - DB loads A via X, then X+1
// RQ2 - FB stores A via X, then X+1
// RQ3 - E4 writes immediate byte to direct page
// RQ4 - accumulator stores in eight modes, flags kept
// RQ5 - X stores direct, direct+Y, absolute
// RQ6 - Y stores direct, direct+X, absolute
// RQ7 - E8 copies A into X, sets NZ
// RQ8 - 9F copies A into Y, sets NZ
// RQ9 - AE copies stack pointer into X
// RQ10 - C8 copies X into A, sets NZ
// RQ11 - 8E copies X into stack pointer
// RQ12 - BF copies Y into A, sets NZ
// RQ13 - EE swaps X and A, four cycles
// RQ14 - DE swaps Y and A, four cycles
// RQ15 - memory byte swapped with A, NZ set
// RQ16 - FE swaps X and Y, four cycles
// RQ17 - word add to Y:A without carry
// RQ18 - word compare sets NZC only
// RQ19 - decrement direct-page word, NZ set
// RQ20 - increment direct-page word, NZ set
// RQ21 - word store and load of Y:A
// RQ22 - word subtract from Y:A without borrow
// RQ23 - loads and the memory swap set NZ, stores and register swaps keep flags
module lsw_exec
	import lsw_pkg::*;
#(
	parameter logic [15:0] RESET_PC = LSW_RST_PC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// software register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// program and data memory
	output logic [15:0] o_mem_addr,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata
);
	// ==========================================
	// state
	lsw_state_t st_r; // sequencer state
	lsw_dec_t dec_r; // decoded opcode
	lsw_dec_t dn; // decode of the fetched byte
	logic [15:0] pc_r; // program counter
	logic [15:0] ea_r; // effective address
	logic [7:0] a_r, x_r, y_r, sp_r, psw_r; // core registers
	logic [7:0] a_nxt, x_nxt, y_nxt, sp_nxt, psw_nxt;
	logic [7:0] b2_r; // immediate operand of the memory load
	logic [7:0] lo_r; // low byte of pointer or word
	logic [7:0] wd_r; // data for the write states
	logic [15:0] res_r; // incremented or decremented word
	logic [3:0] cyc_r; // cycle index within the instruction
	logic run_r; // fetch enable
	logic ill_r; // sticky unknown opcode
	logic [7:0] rdata_r; // register read data
	logic go; // opcode fetch this cycle
	logic [7:0] pg; // direct page high byte
	lsw_state_t fin; // state after the last working cycle
	// word arithmetic
	logic [15:0] ya, w, wop, incd;
	logic [16:0] s17;
	logic [12:0] h13;
	logic sub;

	assign go = (st_r == S_FETCH) && run_r;
	assign dn = lsw_decode(i_mem_rdata);
	assign pg = {7'h00, psw_r[PSW_G]};
	assign fin = (cyc_r >= dec_r.cyc - 4'h1) ? S_FETCH : S_PAD;

	// ==========================================
	// word adder: Y:A against the direct-page pair
	always_comb begin
		ya = {y_r, a_r};
		w = {i_mem_rdata, lo_r};
		sub = (dec_r.op == O_WSUB) || (dec_r.op == O_WCMP);
		wop = sub ? ~w : w;
		s17 = {1'b0, ya} + {1'b0, wop} + {16'h0000, sub};
		h13 = {1'b0, ya[11:0]} + {1'b0, wop[11:0]} + {12'h000, sub};
		incd = (dec_r.op == O_WDEC) ? w - 16'h0001 : w + 16'h0001;
	end

	// ==========================================
	// sequencer: fetch, operands, pointers, accesses, padding
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_r <= S_FETCH;
			dec_r <= '{M_IMP, O_NOP, 4'h2, 1'b0};
			pc_r <= RESET_PC;
			ea_r <= 16'h0000;
			b2_r <= 8'h00;
			lo_r <= 8'h00;
			wd_r <= 8'h00;
			res_r <= 16'h0000;
			cyc_r <= 4'h0;
		end else begin
			// count cycles from the opcode fetch
			cyc_r <= go ? 4'h1 : cyc_r + 4'h1;
			unique case (st_r)
				S_FETCH: begin
					if (go) begin
						dec_r <= dn;
						pc_r <= pc_r + 16'h0001;
						ea_r <= {pg, x_r};
						// implied ops skip operands, X-indirect goes straight to memory
						if (dn.mode == M_IMP)
							st_r <= S_EXEC;
						else if (dn.mode == M_XI || dn.mode == M_XINC)
							st_r <= S_MEM;
						else
							st_r <= S_OPR1;
					end else if (i_reg_wr && !run_r && i_reg_addr == REG_PCL) begin
						pc_r[7:0] <= i_reg_wdata;
					end else if (i_reg_wr && !run_r && i_reg_addr == REG_PCH) begin
						pc_r[15:8] <= i_reg_wdata;
					end
				end
				S_OPR1: begin
					pc_r <= pc_r + 16'h0001;
					lo_r <= i_mem_rdata;
					unique case (dec_r.mode)
						// immediate loads finish here
						M_IMM: st_r <= fin;
						M_ABS, M_ABSY: st_r <= S_OPR2;
						M_DPI: begin
							ea_r <= {pg, i_mem_rdata};
							st_r <= S_OPR2;
						end
						M_DPX: begin
							ea_r <= {pg, i_mem_rdata + x_r};
							st_r <= S_MEM;
						end
						M_DPY: begin
							ea_r <= {pg, i_mem_rdata + y_r};
							st_r <= S_MEM;
						end
						M_IDX: begin
							ea_r <= {pg, i_mem_rdata + x_r};
							st_r <= S_PTRLO;
						end
						M_IDY: begin
							ea_r <= {pg, i_mem_rdata};
							st_r <= S_PTRLO;
						end
						default: begin
							ea_r <= {pg, i_mem_rdata};
							st_r <= S_MEM;
						end
					endcase
				end
				S_OPR2: begin
					pc_r <= pc_r + 16'h0001;
					b2_r <= i_mem_rdata;
					// absolute forms build the address, the memory load keeps its page address
					if (dec_r.mode == M_ABS)
						ea_r <= {i_mem_rdata, lo_r};
					else if (dec_r.mode == M_ABSY)
						ea_r <= {i_mem_rdata, lo_r} + {8'h00, y_r};
					st_r <= S_MEM;
				end
				S_PTRLO: begin
					// pointer low byte, high byte stays in the page
					lo_r <= i_mem_rdata;
					ea_r[7:0] <= ea_r[7:0] + 8'h01;
					st_r <= S_PTRHI;
				end
				S_PTRHI: begin
					if (dec_r.mode == M_IDY)
						ea_r <= {i_mem_rdata, lo_r} + {8'h00, y_r};
					else
						ea_r <= {i_mem_rdata, lo_r};
					st_r <= S_MEM;
				end
				S_MEM: begin
					lo_r <= i_mem_rdata;
					unique case (dec_r.op)
						// swap writes the old accumulator back
						O_XMA: begin
							wd_r <= a_r; // RQ15
							st_r <= S_WR;
						end
						O_WADD, O_WSUB, O_WCMP, O_WINC, O_WDEC, O_WLD, O_WST: begin
							ea_r[7:0] <= ea_r[7:0] + 8'h01;
							st_r <= S_HI;
						end
						default: st_r <= fin;
					endcase
				end
				S_HI: begin
					res_r <= incd; // RQ19 RQ20
					if (dec_r.op == O_WINC || dec_r.op == O_WDEC)
						st_r <= S_WR1;
					else
						st_r <= fin;
				end
				S_WR1: begin
					// high byte first, then step back for the low byte
					ea_r[7:0] <= ea_r[7:0] - 8'h01;
					wd_r <= res_r[7:0];
					st_r <= S_WR;
				end
				S_WR: st_r <= fin;
				S_EXEC: st_r <= fin;
				S_PAD: st_r <= fin;
			endcase
		end
	end

	// ==========================================
	// memory port, driven from the sequencer state
	always_comb begin
		o_mem_addr = ea_r;
		o_mem_rd = 1'b0;
		o_mem_wr = 1'b0;
		o_mem_wdata = 8'h00;
		unique case (st_r)
			S_FETCH: begin
				o_mem_addr = pc_r;
				o_mem_rd = go;
			end
			S_OPR1, S_OPR2: begin
				o_mem_addr = pc_r;
				o_mem_rd = 1'b1;
			end
			S_PTRLO, S_PTRHI: o_mem_rd = 1'b1;
			S_MEM: begin
				unique case (dec_r.op)
					O_STA, O_WST: begin
						o_mem_wr = 1'b1;
						o_mem_wdata = a_r; // RQ4 RQ21
					end
					O_STX: begin
						o_mem_wr = 1'b1;
						o_mem_wdata = x_r; // RQ5
					end
					O_STY: begin
						o_mem_wr = 1'b1;
						o_mem_wdata = y_r; // RQ6
					end
					O_STI: begin
						o_mem_wr = 1'b1;
						o_mem_wdata = b2_r; // RQ3
					end
					default: o_mem_rd = 1'b1;
				endcase
			end
			S_HI: begin
				if (dec_r.op == O_WST) begin
					o_mem_wr = 1'b1;
					o_mem_wdata = y_r; // RQ21
				end else begin
					o_mem_rd = 1'b1;
				end
			end
			S_WR1: begin
				o_mem_wr = 1'b1;
				o_mem_wdata = res_r[15:8];
			end
			S_WR: begin
				o_mem_wr = 1'b1;
				o_mem_wdata = wd_r;
			end
			S_EXEC, S_PAD: o_mem_rd = 1'b0;
		endcase
	end

	// ==========================================
	// next values of the core registers and flags
	always_comb begin
		a_nxt = a_r;
		x_nxt = x_r;
		y_nxt = y_r;
		sp_nxt = sp_r;
		psw_nxt = psw_r;
		// byte loads, from an immediate or from memory
		if ((st_r == S_OPR1 && dec_r.mode == M_IMM) || st_r == S_MEM) begin
			unique case (dec_r.op)
				O_LDA, O_XMA: a_nxt = i_mem_rdata; // RQ15
				O_LDX: x_nxt = i_mem_rdata;
				O_LDY: y_nxt = i_mem_rdata;
				default: a_nxt = a_r;
			endcase
			if (dec_r.op == O_LDA || dec_r.op == O_LDX || dec_r.op == O_LDY
				|| dec_r.op == O_XMA) begin
				psw_nxt[PSW_N] = i_mem_rdata[7]; // RQ23
				psw_nxt[PSW_Z] = (i_mem_rdata == 8'h00);
			end
		end
		// post-increment of X after the access
		if (st_r == S_MEM && dec_r.mode == M_XINC)
			x_nxt = x_r + 8'h01; // RQ1 RQ2
		// register transfers and swaps
		if (st_r == S_EXEC) begin
			unique case (dec_r.op)
				O_TAX: x_nxt = a_r; // RQ7
				O_TAY: y_nxt = a_r; // RQ8
				O_TSX: x_nxt = sp_r; // RQ9
				O_TXA: a_nxt = x_r; // RQ10
				O_TXS: sp_nxt = x_r; // RQ11
				O_TYA: a_nxt = y_r; // RQ12
				O_XAX: begin
					x_nxt = a_r; // RQ13
					a_nxt = x_r;
				end
				O_XAY: begin
					y_nxt = a_r; // RQ14
					a_nxt = y_r;
				end
				O_XYX: begin
					x_nxt = y_r; // RQ16
					y_nxt = x_r;
				end
				default: a_nxt = a_r;
			endcase
			// transfers set NZ from the moved byte, swaps keep flags
			unique case (dec_r.op)
				O_TAX, O_TAY, O_TXA, O_TXS: begin
					psw_nxt[PSW_N] = a_r[7] & (dec_r.op != O_TXA) & (dec_r.op != O_TXS)
						| x_r[7] & ((dec_r.op == O_TXA) | (dec_r.op == O_TXS));
					psw_nxt[PSW_Z] = (dec_r.op == O_TXA || dec_r.op == O_TXS) ?
						(x_r == 8'h00) : (a_r == 8'h00);
				end
				O_TSX: begin
					psw_nxt[PSW_N] = sp_r[7];
					psw_nxt[PSW_Z] = (sp_r == 8'h00);
				end
				O_TYA: begin
					psw_nxt[PSW_N] = y_r[7];
					psw_nxt[PSW_Z] = (y_r == 8'h00);
				end
				default: psw_nxt = psw_r;
			endcase
		end
		// word ops, high byte in hand
		if (st_r == S_HI) begin
			unique case (dec_r.op)
				O_WADD, O_WSUB: begin
					{y_nxt, a_nxt} = s17[15:0]; // RQ17 RQ22
					psw_nxt[PSW_N] = s17[15];
					psw_nxt[PSW_V] = (ya[15] == wop[15]) && (s17[15] != ya[15]);
					psw_nxt[PSW_H] = h13[12];
					psw_nxt[PSW_Z] = (s17[15:0] == 16'h0000);
					psw_nxt[PSW_C] = s17[16];
				end
				O_WCMP: begin
					psw_nxt[PSW_N] = s17[15]; // RQ18
					psw_nxt[PSW_Z] = (s17[15:0] == 16'h0000);
					psw_nxt[PSW_C] = s17[16];
				end
				O_WINC, O_WDEC: begin
					psw_nxt[PSW_N] = incd[15]; // RQ19 RQ20
					psw_nxt[PSW_Z] = (incd == 16'h0000);
				end
				O_WLD: begin
					{y_nxt, a_nxt} = w; // RQ21
					psw_nxt[PSW_N] = w[15];
					psw_nxt[PSW_Z] = (w == 16'h0000);
				end
				default: psw_nxt = psw_r;
			endcase
		end
	end

	// ==========================================
	// core register file
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			a_r <= 8'h00;
			x_r <= 8'h00;
			y_r <= 8'h00;
			sp_r <= LSW_RST_SP;
			psw_r <= LSW_RST_PSW;
		end else begin
			a_r <= a_nxt;
			x_r <= x_nxt;
			y_r <= y_nxt;
			sp_r <= sp_nxt;
			psw_r <= psw_nxt;
		end
	end

	// ==========================================
	// software registers: run control, sticky error, read back
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			run_r <= 1'b0;
			ill_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			if (i_reg_wr && i_reg_addr == REG_CTRL)
				run_r <= i_reg_wdata[0];
			// an unknown opcode in the clearing cycle still sets the flag
			if (go && dn.ill)
				ill_r <= 1'b1;
			else if (i_reg_wr && i_reg_addr == REG_STAT && i_reg_wdata[0])
				ill_r <= 1'b0;
			rdata_r <= 8'h00;
			if (i_reg_rd) begin
				case (i_reg_addr)
					REG_CTRL: rdata_r <= {7'h00, run_r};
					REG_STAT: rdata_r <= {6'h00, st_r == S_FETCH, ill_r};
					REG_ACC: rdata_r <= a_r;
					REG_IDX: rdata_r <= x_r;
					REG_IDY: rdata_r <= y_r;
					REG_SP: rdata_r <= sp_r;
					REG_PSW: rdata_r <= psw_r;
					REG_PCL: rdata_r <= pc_r[7:0];
					REG_PCH: rdata_r <= pc_r[15:8];
					default: rdata_r <= 8'h00;
				endcase
			end
		end
	end
	assign o_reg_rdata = rdata_r;

	// ==========================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	property p_ldinc;
		go && i_mem_rdata == OPC_LDA_XINC |-> ##4 (st_r == S_FETCH
			&& x_r == $past(x_r, 4) + 8'h01 && a_r == $past(i_mem_rdata, 3));
	endproperty
	a_ldinc: assert property (p_ldinc) else $error("auto-increment load wrong"); // RQ1
	property p_stinc;
		go && i_mem_rdata == OPC_STA_XINC |=> (o_mem_wr && o_mem_addr[7:0] == $past(x_r)
			&& o_mem_wdata == a_r) ##3 (st_r == S_FETCH && x_r == $past(x_r, 4) + 8'h01);
	endproperty
	a_stinc: assert property (p_stinc) else $error("auto-increment store wrong"); // RQ2
	property p_ldm;
		go && i_mem_rdata == OPC_LDM |-> ##3 (o_mem_wr && o_mem_wdata == $past(i_mem_rdata))
			##2 (st_r == S_FETCH);
	endproperty
	a_ldm: assert property (p_ldm) else $error("immediate memory write wrong"); // RQ3
	property p_stdp;
		go && i_mem_rdata == OPC_STA_DP |-> ##2 (o_mem_wr && o_mem_wdata == a_r)
			##2 (st_r == S_FETCH && psw_r == $past(psw_r, 4));
	endproperty
	a_stdp: assert property (p_stdp) else $error("direct store wrong"); // RQ4
	property p_tax;
		go && i_mem_rdata == OPC_TAX |-> ##2 (st_r == S_FETCH && x_r == $past(a_r, 2)
			&& psw_r[PSW_Z] == ($past(a_r, 2) == 8'h00));
	endproperty
	a_tax: assert property (p_tax) else $error("copy to X wrong"); // RQ7
	property p_txs;
		go && i_mem_rdata == OPC_TXS |-> ##2 (sp_r == $past(x_r, 2) && st_r == S_FETCH);
	endproperty
	a_txs: assert property (p_txs) else $error("copy to stack pointer wrong"); // RQ11
	property p_xax;
		go && i_mem_rdata == OPC_XAX |-> ##4 (st_r == S_FETCH && x_r == $past(a_r, 4)
			&& a_r == $past(x_r, 4) && psw_r == $past(psw_r, 4));
	endproperty
	a_xax: assert property (p_xax) else $error("swap of X and A wrong"); // RQ13
	property p_wcmp;
		go && i_mem_rdata == OPC_WCMP |-> ##4 (st_r == S_FETCH && a_r == $past(a_r, 4)
			&& y_r == $past(y_r, 4));
	endproperty
	a_wcmp: assert property (p_wcmp) else $error("word compare changed Y:A"); // RQ18
	c_wadd: cover property (go && i_mem_rdata == OPC_WADD ##5 st_r == S_FETCH);
	c_winc: cover property (go && i_mem_rdata == OPC_WINC ##4 o_mem_wr ##1 o_mem_wr);
	c_xma: cover property (go && i_mem_rdata == OPC_XMA_XI ##2 o_mem_wr);
endmodule // lsw_exec
`default_nettype wire

// *** verification/lsw_mem.sv ***
// behavioural program and data memory facing the load/store unit
// assumes read data in the same cycle as the address, writes on the rising edge
`timescale 1ns/1ps
`default_nettype none
module lsw_mem (
	// clock
	input wire logic i_clk,
	// access port
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	// ==========================================
	// storage, cleared at start and preloaded by the bench
	logic [7:0] ram [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) begin
			ram[i] = 8'h00;
		end
	end
	// data only valid under the read strobe, else the inverse so stale data never matches
	assign o_rdata = i_rd ? ram[i_addr] : ~ram[i_addr];
	// write lands on the edge that ends the write cycle
	always @(posedge i_clk) begin
		if (i_wr) begin
			ram[i_addr] <= i_wdata;
		end
	end
endmodule // lsw_mem
`default_nettype wire

// *** verification/cpu_load_store_word_ops_test.sv ***
// self-checking bench for the load/store and word instruction unit
// assumes the memory model answers in the same cycle; code runs from 0200
`timescale 1ns/1ps
`default_nettype none
module cpu_load_store_word_ops_test;
	import lsw_pkg::*;
	// ==========================================
	// signals
	logic i_core_clk, i_reset, i_reg_wr, i_reg_rd, o_mem_rd, o_mem_wr;
	logic [3:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata, o_mem_wdata, i_mem_rdata;
	logic [15:0] o_mem_addr;
	int failures = 0;
	int num_checks = 0;
	int cycn = 0;
	// store rows: opcode, op1, op2, length, cycles, address hi, lo, value
	logic [7:0] st [8][8] = '{'{8'hE5,8'h60,8'h00,8'h2,8'h4,8'h00,8'h60,8'h11},
		'{8'hE6,8'h40,8'h00,8'h2,8'h5,8'h00,8'hE2,8'h11},
		'{8'hE7,8'h61,8'h03,8'h3,8'h5,8'h03,8'h61,8'h11},
		'{8'hF6,8'h10,8'h00,8'h2,8'h7,8'h03,8'h70,8'h11},
		'{8'hEC,8'h64,8'h00,8'h2,8'h4,8'h00,8'h64,8'hA2},
		'{8'hFC,8'h65,8'h03,8'h3,8'h5,8'h03,8'h65,8'hA2},
		'{8'hE9,8'h66,8'h00,8'h2,8'h4,8'h00,8'h66,8'hB3},
		'{8'hF8,8'h67,8'h03,8'h3,8'h5,8'h03,8'h67,8'hB3}};
	// register rows: opcode, cycles, a, y, x, reg, value, reg, value, flags
	logic [7:0] rg [9][10] = '{'{8'hE8,8'h2,8'h11,8'h00,8'h85,8'h3,8'h11,8'h3,8'h11,8'h00},
		'{8'h9F,8'h2,8'h11,8'h00,8'h85,8'h4,8'h11,8'h4,8'h11,8'h00},
		'{8'hAE,8'h2,8'h11,8'h00,8'h85,8'h3,8'hFF,8'h3,8'hFF,8'h80},
		'{8'hC8,8'h2,8'h11,8'h00,8'h85,8'h2,8'h85,8'h2,8'h85,8'h80},
		'{8'h8E,8'h2,8'h11,8'h00,8'h85,8'h5,8'h85,8'h5,8'h85,8'h80},
		'{8'hBF,8'h2,8'h11,8'h00,8'h85,8'h2,8'h00,8'h2,8'h00,8'h02},
		'{8'hEE,8'h4,8'h11,8'h22,8'h93,8'h2,8'h93,8'h3,8'h11,8'h80},
		'{8'hDE,8'h4,8'h11,8'h22,8'h93,8'h2,8'h22,8'h4,8'h11,8'h80},
		'{8'hFE,8'h4,8'h11,8'h22,8'h93,8'h3,8'h22,8'h4,8'h93,8'h80}};
	// word rows: opcode, cycles, x, a, y, word lo, word hi, flags
	logic [7:0] wd [8][8] = '{'{8'h1D,8'h5,8'h01,8'h00,8'h80,8'hFF,8'h7F,8'hC8},
		'{8'h3D,8'h5,8'h01,8'h02,8'h80,8'hFF,8'h7F,8'h80},
		'{8'h5D,8'h4,8'h01,8'h01,8'h00,8'hFF,8'h7F,8'h80},
		'{8'h7D,8'h5,8'h80,8'hFF,8'h7F,8'hFF,8'h7F,8'h00},
		'{8'hDD,8'h5,8'h80,8'h01,8'h00,8'h01,8'h00,8'h80},
		'{8'h9D,8'h6,8'h00,8'h01,8'h00,8'h00,8'h80,8'h80},
		'{8'hBD,8'h6,8'h80,8'h01,8'h00,8'hFE,8'h7F,8'h00},
		'{8'hBC,8'h5,8'h01,8'hFF,8'h00,8'h01,8'h7F,8'h80}};
	// ==========================================
	// design and memory
	lsw_exec DUT (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
		.o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata));
	lsw_mem mem (.i_clk(i_core_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	// ==========================================
	// clock, cycle counter and watchdog
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) cycn <= cycn + 1;
	initial begin
		repeat (20000) @(posedge i_core_clk);
		failures++;
		summarize();
	end
	// ==========================================
	// shared tasks
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_reg_addr <= a[3:0];
		i_reg_rd <= 1'b1;
		@(posedge i_core_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_core_clk);
		chk("register", o_reg_rdata, exp);
	endtask
	// waits for an opcode fetch at one address, bounded
	task automatic wait_fetch(input logic [15:0] a, output int t);
		int n;
		n = 0;
		@(negedge i_core_clk);
		while (!(o_mem_rd === 1'b1 && o_mem_addr === a) && n < 300) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n >= 300) begin
			failures++;
			$display("BAD fetch at %h expected 1 seen 0", a);
		end
		t = cycn;
	endtask
	// loads a, y, x by immediates, then runs one instruction and times it
	task automatic run(input logic [7:0] a, y, x, b0, b1, b2, input int len, input int ncyc);
		logic [7:0] p [9];
		int t0;
		int t1;
		p = '{8'hC4, a, 8'h3E, y, 8'h1E, x, b0, b1, b2};
		reg_wr(REG_CTRL, 8'h00);
		repeat (12) @(posedge i_core_clk);
		for (int i = 0; i < 16; i++) mem.ram[16'h0200 + i] = (i < 9) ? p[i] : 8'h00;
		reg_wr(REG_PCL, 8'h00);
		reg_wr(REG_PCH, 8'h02);
		reg_wr(REG_CTRL, 8'h01);
		wait_fetch(16'h0206, t0);
		wait_fetch(16'h0206 + 16'(len), t1);
		chk("cycles", 8'(t1 - t0), 8'(ncyc));
		reg_wr(REG_CTRL, 8'h00);
		repeat (12) @(posedge i_core_clk);
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		reg_chk(8'h2, 8'h00);
		reg_chk(8'h5, 8'hFF);
		reg_chk(8'h6, 8'h00);
		reg_chk(8'hF, 8'h00);
	endtask
	task automatic t_xinc();
		mem.ram[16'h0030] = 8'h80;
		run(8'h00, 8'h00, 8'h30, 8'hDB, 8'h00, 8'h00, 1, 4);
		reg_chk(8'h2, 8'h80);
		reg_chk(8'h3, 8'h31);
		reg_chk(8'h6, 8'h80);
		run(8'h77, 8'h00, 8'h40, 8'hFB, 8'h00, 8'h00, 1, 4);
		chk("stored byte", mem.ram[16'h0040], 8'h77);
		reg_chk(8'h3, 8'h41);
		run(8'h00, 8'h00, 8'h01, 8'hE4, 8'h50, 8'h99, 3, 5);
		chk("immediate byte", mem.ram[16'h0050], 8'h99);
	endtask
	task automatic t_store();
		mem.ram[16'h00B2] = 8'h70;
		mem.ram[16'h00B3] = 8'h03;
		for (int i = 0; i < 8; i++) begin
			mem.ram[{st[i][5], st[i][6]}] = 8'h00;
			run(8'h11, 8'hB3, 8'hA2, st[i][0], st[i][1], st[i][2], st[i][3], st[i][4]);
			chk("stored byte", mem.ram[{st[i][5], st[i][6]}], st[i][7]);
			reg_chk(8'h6, 8'h80);
		end
	endtask
	task automatic t_regs();
		for (int i = 0; i < 9; i++) begin
			run(rg[i][2], rg[i][3], rg[i][4], rg[i][0], 8'h00, 8'h00, 1, rg[i][1]);
			reg_chk(rg[i][5], rg[i][6]);
			reg_chk(rg[i][7], rg[i][8]);
			reg_chk(8'h6, rg[i][9]);
		end
	endtask
	task automatic t_word();
		for (int i = 0; i < 8; i++) begin
			mem.ram[16'h0080] = 8'hFF;
			mem.ram[16'h0081] = 8'h7F;
			run(8'h01, 8'h00, wd[i][2], wd[i][0], 8'h80, 8'h00, 2, wd[i][1]);
			reg_chk(8'h2, wd[i][3]);
			reg_chk(8'h4, wd[i][4]);
			chk("word low", mem.ram[16'h0080], wd[i][5]);
			chk("word high", mem.ram[16'h0081], wd[i][6]);
			reg_chk(8'h6, wd[i][7]);
		end
	endtask
	// ==========================================
	// verdict and end of run
	task automatic summarize();
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========================================
	// main sequence: reset for 12 cycles, then the scenarios
	initial begin
		i_reset = 1'b1;
		i_reg_addr = 4'h0;
		i_reg_wdata = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		repeat (12) @(posedge i_core_clk);
		i_reset <= 1'b0;
		t_reset();
		t_xinc();
		t_store();
		t_regs();
		t_word();
		summarize();
	end
endmodule // cpu_load_store_word_ops_test
`default_nettype wire
